// *** msd_defs.svh ***
// Offsets, field positions, encodings and reset values of the MAC datapath
`ifndef MSD_DEFS_SVH
`define MSD_DEFS_SVH

// ==========================================================
// Register offsets
`define MSD_ADDR_STATUS 8'h00
`define MSD_ADDR_ACC_LO 8'h10
`define MSD_ADDR_ACC_EXT 8'h20
`define MSD_ADDR_ACC_MASK 8'hF3

// ==========================================================
// Status word field positions
`define MSD_FLD_EXT 0
`define MSD_FLD_V 1
`define MSD_FLD_Z 2
`define MSD_FLD_N 3
`define MSD_FLD_FMT_LSB 5
`define MSD_FLD_FMT_MSB 6
`define MSD_FLD_SAT 7
`define MSD_FLD_STICKY_LSB 8
`define MSD_FLD_STICKY_MSB 11

// ==========================================================
// Operand format and scale factor encodings
`define MSD_FMT_SINT 2'h0
`define MSD_FMT_UINT 2'h2
`define MSD_SCALE_NONE 2'h0
`define MSD_SCALE_LEFT 2'h1
`define MSD_SCALE_RSVD 2'h2
`define MSD_SCALE_RIGHT 2'h3

// ==========================================================
// Saturation values and special patterns
`define MSD_SINT_MAX 48'h0000_7FFF_FFFF
`define MSD_SINT_MIN 48'hFFFF_8000_0000
`define MSD_FRAC_MAX 48'h007F_FFFF_FF00
`define MSD_FRAC_MIN 48'hFF80_0000_0000
`define MSD_UINT_MAX 48'hFFFF_FFFF_FFFF
`define MSD_UINT_MIN 48'h0000_0000_0000
`define MSD_FRAC_NEG_ONE 32'h8000_0000

// ==========================================================
// Reset values
`define MSD_FMT_RST 2'h0
`define MSD_ACC_RST 48'h0000_0000_0000

`endif

// *** msd_pkg.sv ***
// Types shared by the MAC datapath and its users
package msd_pkg;

   // ==========================================================
   // Multiply-accumulate request from the core pipeline
   typedef struct packed {
      logic subtract;
      logic long_size;
      logic upper_half_sel_x;
      logic upper_half_sel_y;
      logic [1:0] product_scale_factor;
      logic [1:0] acc_idx;
      logic [31:0] operand_x;
      logic [31:0] operand_y;
   } msd_op_type;

   // ==========================================================
   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } msd_bus_type;

   // ==========================================================
   // Condition flags
   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic extension_flag;
   } msd_flags_type;

endpackage

// *** msd_datapath.sv ***
// Multiply-accumulate datapath with four 48-bit accumulators
//
// Contract
// - Status bits 6:5 select operand format
// - Fraction patterns: most negative means minus one
// - N and Z follow final accumulate step
// - V on 40-bit product or accumulate overflow
// - V equals selected sticky bit after op
// - Scale product before accumulate, else unshifted
// - Fractional mode ignores scale factor
// - Unsigned right shift inserts zero
// - Signed right shift inserts sign, zero exceptions
// - Left shift inserts zero at lsb
// - Scale field: none, left, reserved, right
// - Run only if saturate off or sticky clear
// - Word halves chosen and sign-extended, zero-extended if unsigned
// - Product overflow when bits 63:39 mixed, unsigned when 63:40 nonzero
// - Product overflow saturates by sign and op
// - Product bit 39 extended to 48 bits
// - Result is accumulator plus or minus product
// - Accumulate overflow sets sticky, may saturate
// - N is bit 47, Z all bits zero
// - Extension flag from bits 47:31 uniformity in signed integer mode
// - Fraction word half placed in upper bits
// - Fraction product doubled by left shift
`timescale 1ns/100ps
`include "msd_defs.svh"

module msd_datapath (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Core pipeline request
   input wire logic i_mac_req,
   input wire msd_pkg::msd_op_type i_mac_op,
   // Register bus
   input wire msd_pkg::msd_bus_type i_bus,
   output logic [31:0] o_bus_rdata,
   // Operation results
   output logic o_mac_done,
   output msd_pkg::msd_flags_type o_flags
);
   import msd_pkg::*;

   localparam int N_ACC = 4;

   // ==========================================================
   // Functions

   // Operand selection per format and size
   function automatic logic [31:0] pick_operand(input logic [31:0] src, input logic upper,
                                                input logic long_size, input logic [1:0] fmt);
      logic [15:0] half;
      half = upper ? src[31:16] : src[15:0];
      if (long_size) begin
         pick_operand = src;
      end else if (fmt[0]) begin
         pick_operand = {half, 16'h0000};
      end else if (fmt == `MSD_FMT_UINT) begin
         pick_operand = {16'h0000, half};
      end else begin
         pick_operand = {{16{half[15]}}, half};
      end
   endfunction

   // Extension flag per format
   function automatic logic ext_of(input logic [47:0] v, input logic [1:0] fmt);
      if (fmt[0]) begin
         ext_of = !((&v[47:39]) || !(|v[47:39]));
      end else if (fmt == `MSD_FMT_UINT) begin
         ext_of = |v[47:32];
      end else begin
         ext_of = !((&v[47:31]) || !(|v[47:31]));
      end
   endfunction

   // ==========================================================
   // State
   logic [47:0] acc [N_ACC];
   logic [N_ACC-1:0] sticky_overflow_bit;
   logic [1:0] fmt;
   logic overflow_saturate_ctl;
   msd_flags_type flags;
   logic [1:0] last_idx;

   // ==========================================================
   // Format decode
   wire is_frac = fmt[0];
   wire is_uint = (fmt == `MSD_FMT_UINT);
   wire is_sint = (fmt == `MSD_FMT_SINT);
   wire is_signed = !is_uint;

   // ==========================================================
   // Gating of the operation
   wire [47:0] acc_sel = acc[i_mac_op.acc_idx];
   wire sticky_sel = sticky_overflow_bit[i_mac_op.acc_idx];
   wire blocked = overflow_saturate_ctl & sticky_sel;
   wire op_go = i_mac_req & ~blocked;

   // ==========================================================
   // Operands and multiply
   wire [31:0] op_x = pick_operand(i_mac_op.operand_x, i_mac_op.upper_half_sel_x, i_mac_op.long_size, fmt);
   wire [31:0] op_y = pick_operand(i_mac_op.operand_y, i_mac_op.upper_half_sel_y, i_mac_op.long_size, fmt);
   wire signed [63:0] prod_signed = $signed(op_y) * $signed(op_x);
   wire [63:0] prod_unsigned = op_y * op_x;
   wire [63:0] prod_raw = is_signed ? prod_signed : prod_unsigned;

   // ==========================================================
   // Product overflow, integer modes only
   wire sint_povf = !((&prod_raw[63:39]) || !(|prod_raw[63:39]));
   wire uint_povf = |prod_raw[63:40];
   wire prod_ovf = is_sint ? sint_povf : (is_uint ? uint_povf : 1'b0);

   // ==========================================================
   // Integer product extension and scaling
   wire [47:0] int_ext = is_signed ? {{8{prod_raw[39]}}, prod_raw[39:0]} : {8'h00, prod_raw[39:0]};
   // Zero fill keeps a wrapped product from posing as a valid sign
   wire rs_fill = is_signed & prod_raw[39] & ~(i_mac_op.long_size & prod_ovf);
   wire [47:0] int_left = {int_ext[47:41], int_ext[39:0], 1'b0};
   wire [47:0] int_right = {int_ext[47:40], rs_fill, int_ext[39:1]};
   wire [1:0] scale_sel = i_mac_op.product_scale_factor;
   wire [47:0] int_scaled = (scale_sel == `MSD_SCALE_LEFT) ? int_left :
                            (scale_sel == `MSD_SCALE_RIGHT) ? int_right : int_ext;

   // ==========================================================
   // Fractional product: doubled, extended, upper 48 bits kept
   wire [63:0] prod_dbl = {prod_raw[62:0], 1'b0};
   // Minus one squared: zero fill, the accumulate check catches it
   wire both_neg_one = (op_x == `MSD_FRAC_NEG_ONE) && (op_y == `MSD_FRAC_NEG_ONE);
   wire [71:0] frac_ext = both_neg_one ? {8'h00, prod_dbl} : {{8{prod_dbl[63]}}, prod_dbl};
   wire [47:0] frac_prod = frac_ext[71:24];

   // Scale factor has no say in fractional mode
   wire [47:0] scaled = is_frac ? frac_prod : int_scaled;

   // ==========================================================
   // Accumulate
   wire [48:0] acc_ext49 = {is_signed & acc_sel[47], acc_sel};
   wire [48:0] prod_ext49 = {is_signed & scaled[47], scaled};
   wire [48:0] sum49 = i_mac_op.subtract ? acc_ext49 - prod_ext49 : acc_ext49 + prod_ext49;
   wire aovf_raw = is_signed ? (sum49[48] ^ sum49[47]) : sum49[48];
   // Overflowed product is not accumulated into the overflow check
   wire acc_ovf = ~prod_ovf & aovf_raw;
   wire new_sticky = prod_ovf | acc_ovf;

   // ==========================================================
   // Saturation values
   wire [47:0] sint_prod_sat = (prod_raw[63] ^ i_mac_op.subtract) ? `MSD_SINT_MIN : `MSD_SINT_MAX;
   wire [47:0] sint_acc_sat = sum49[47] ? `MSD_SINT_MAX : `MSD_SINT_MIN;
   wire [47:0] frac_acc_sat = sum49[47] ? `MSD_FRAC_MAX : `MSD_FRAC_MIN;
   wire [47:0] uint_sat = i_mac_op.subtract ? `MSD_UINT_MIN : `MSD_UINT_MAX;
   wire [47:0] sat_val = is_uint ? uint_sat :
                         is_frac ? frac_acc_sat :
                         prod_ovf ? sint_prod_sat : sint_acc_sat;
   wire saturate = overflow_saturate_ctl & new_sticky;
   wire [47:0] result = saturate ? sat_val : sum49[47:0];

   // ==========================================================
   // Value the selected accumulator holds after the request
   wire [47:0] next_sel = blocked ? acc_sel : result;
   wire next_v = blocked ? 1'b1 : new_sticky;

   // ==========================================================
   // Register bus decode
   wire bus_wr_status = i_bus.wr && (i_bus.addr == `MSD_ADDR_STATUS);
   wire bus_hit_lo = ((i_bus.addr & `MSD_ADDR_ACC_MASK) == `MSD_ADDR_ACC_LO);
   wire bus_hit_ext = ((i_bus.addr & `MSD_ADDR_ACC_MASK) == `MSD_ADDR_ACC_EXT);
   wire [1:0] bus_idx = i_bus.addr[3:2];
   wire [47:0] bus_acc = acc[bus_idx];
   wire [31:0] status_word = {20'h00000,
                              sticky_overflow_bit,
                              overflow_saturate_ctl,
                              fmt,
                              1'b0,
                              flags.n,
                              flags.z,
                              flags.v,
                              flags.extension_flag};
   wire [31:0] rd_word = (i_bus.addr == `MSD_ADDR_STATUS) ? status_word :
                         bus_hit_lo ? bus_acc[31:0] :
                         bus_hit_ext ? {16'h0000, bus_acc[47:32]} : 32'h0000_0000;
   wire [31:0] next_rdata = i_bus.rd ? rd_word : 32'h0000_0000;

   // ==========================================================
   // Mode and saturation control, software owned
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         fmt <= `MSD_FMT_RST;
         overflow_saturate_ctl <= 1'b0;
      end else if (bus_wr_status) begin
         fmt <= i_bus.wdata[`MSD_FLD_FMT_MSB:`MSD_FLD_FMT_LSB];
         overflow_saturate_ctl <= i_bus.wdata[`MSD_FLD_SAT];
      end
   end

   // ==========================================================
   // Accumulators; a running operation wins over a bus write
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < N_ACC; k++) begin
            acc[k] <= `MSD_ACC_RST;
         end
      end else begin
         for (int k = 0; k < N_ACC; k++) begin
            if (op_go && (i_mac_op.acc_idx == 2'(k))) begin
               acc[k] <= result;
            end else if (i_bus.wr && bus_hit_lo && (bus_idx == 2'(k))) begin
               acc[k][31:0] <= i_bus.wdata;
            end else if (i_bus.wr && bus_hit_ext && (bus_idx == 2'(k))) begin
               acc[k][47:32] <= i_bus.wdata[15:0];
            end
         end
      end
   end

   // ==========================================================
   // Sticky bits: cleared then recomputed by the operation
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sticky_overflow_bit <= '0;
      end else begin
         for (int k = 0; k < N_ACC; k++) begin
            if (op_go && (i_mac_op.acc_idx == 2'(k))) begin
               sticky_overflow_bit[k] <= new_sticky;
            end else if (bus_wr_status) begin
               sticky_overflow_bit[k] <= i_bus.wdata[`MSD_FLD_STICKY_LSB + k];
            end
         end
      end
   end

   // ==========================================================
   // Flags; a request wins over a bus write in the same cycle
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         flags <= '0;
      end else if (i_mac_req) begin
         flags.n <= next_sel[47];
         flags.z <= (next_sel == 48'h0000_0000_0000);
         flags.v <= next_v;
         flags.extension_flag <= ext_of(next_sel, fmt);
      end else if (bus_wr_status) begin
         flags.n <= i_bus.wdata[`MSD_FLD_N];
         flags.z <= i_bus.wdata[`MSD_FLD_Z];
         flags.v <= i_bus.wdata[`MSD_FLD_V];
         flags.extension_flag <= i_bus.wdata[`MSD_FLD_EXT];
      end
   end

   // ==========================================================
   // Completion and read data
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_mac_done <= 1'b0;
         last_idx <= 2'h0;
         o_bus_rdata <= 32'h0000_0000;
      end else begin
         o_mac_done <= i_mac_req;
         o_bus_rdata <= next_rdata;
         if (i_mac_req) begin
            last_idx <= i_mac_op.acc_idx;
         end
      end
   end

   assign o_flags = flags;

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   wire [47:0] acc_after = acc[last_idx];
   wire [47:0] ref_sum = i_mac_op.subtract ? acc_sel - scaled : acc_sel + scaled;

   AST_BLOCKED_HOLDS: assert property (
      (i_mac_req && overflow_saturate_ctl && sticky_sel) |=> (acc_after == $past(acc_sel)) && o_flags.v
   ) else $error("blocked request changed the accumulator");

   AST_V_IS_STICKY: assert property (
      o_mac_done |-> (o_flags.v == sticky_overflow_bit[last_idx])
   ) else $error("overflow flag differs from sticky bit");

   AST_NZ_FROM_ACC: assert property (
      o_mac_done |-> (o_flags.n == acc_after[47]) && (o_flags.z == (acc_after == 48'h0000_0000_0000))
   ) else $error("negative or zero flag wrong");

   AST_EXT_SINT: assert property (
      (o_mac_done && is_sint && !$past(bus_wr_status))
         |-> (o_flags.extension_flag == !((&acc_after[47:31]) || !(|acc_after[47:31])))
   ) else $error("extension flag wrong in signed integer mode");

   AST_PROD_OVF_STICKY: assert property (
      (op_go && is_sint && sint_povf) |=> sticky_overflow_bit[last_idx] && o_flags.v
   ) else $error("product overflow not recorded");

   AST_PROD_SAT: assert property (
      (op_go && is_sint && sint_povf && overflow_saturate_ctl) |=> (acc_after == $past(sint_prod_sat))
   ) else $error("product overflow saturation value wrong");

   AST_PLAIN_SUM: assert property (
      (op_go && !prod_ovf && !acc_ovf) |=> (acc_after == $past(ref_sum)) && !sticky_overflow_bit[last_idx]
   ) else $error("accumulate result wrong");

   AST_FRAC_PLACE: assert property (
      (i_mac_req && is_frac && !i_mac_op.long_size)
         |-> (op_x[15:0] == 16'h0000) && (op_y[15:0] == 16'h0000)
   ) else $error("fraction word operand misplaced");

   AST_DONE_FOLLOWS: assert property (
      (i_mac_req |=> o_mac_done) and (!i_mac_req |=> !o_mac_done)
   ) else $error("completion pulse out of step with request");

endmodule

// *** msd_core_model.sv ***
// Core pipeline model that issues multiply-accumulate requests
`timescale 1ns/100ps
module msd_core_model (
   // Clock
   input wire logic i_clk_sys,
   // Request to the datapath
   output logic o_mac_req,
   output msd_pkg::msd_op_type o_mac_op
);
   import msd_pkg::*;
   // ==========================================================
   // Request driver
   initial begin
      o_mac_req = 1'b0;
      o_mac_op = '0;
   end
   // All fields of one operation travel in the same cycle
   task automatic issue(input msd_op_type op);
      @(posedge i_clk_sys);
      o_mac_req <= 1'b1;
      o_mac_op <= op;
   endtask
   // Fields are only read with a request; scramble them so stale use shows
   task automatic idle();
      @(posedge i_clk_sys);
      o_mac_req <= 1'b0;
      o_mac_op <= ~o_mac_op;
   endtask
endmodule

// *** msd_datapath_test.sv ***
// Self-checking bench for the multiply-accumulate datapath
`timescale 1ns/100ps
module msd_datapath_test;
   import msd_pkg::*;
   // ==========================================================
   // Signals and reference state
   logic i_clk_sys;
   logic i_rst;
   logic i_mac_req;
   msd_op_type i_mac_op;
   msd_bus_type i_bus;
   logic [31:0] o_bus_rdata;
   logic o_mac_done;
   msd_flags_type o_flags;
   int fail_count = 0;
   int n_compared = 0;
   logic [47:0] m_acc [4];
   logic [3:0] m_sticky;
   logic m_sat;
   logic [1:0] m_fmt;
   logic [3:0] m_fl;
   logic [31:0] rd;

   msd_datapath DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mac_req(i_mac_req), .i_mac_op(i_mac_op),
      .i_bus(i_bus), .o_bus_rdata(o_bus_rdata), .o_mac_done(o_mac_done), .o_flags(o_flags));
   msd_core_model CORE (.i_clk_sys(i_clk_sys), .o_mac_req(i_mac_req), .o_mac_op(i_mac_op));

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   // ==========================================================
   // Tasks
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      i_bus.wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk_sys);
      i_bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      i_bus.rd <= 1'b0;
      #1;
      d = o_bus_rdata;
   endtask

   task automatic set_status(input logic sat, input logic [1:0] fmt);
      bus_wr(8'h00, {24'h0, sat, fmt, 5'h00});
      {m_sat, m_fmt, m_sticky, m_fl} = {sat, fmt, 4'h0, 4'h0};
   endtask

   task automatic chk_all();
      logic [31:0] lo;
      for (int k = 0; k < 4; k++) begin
         bus_rd(8'h10 + 8'(4 * k), lo);
         bus_rd(8'h20 + 8'(4 * k), rd);
         check({rd[15:0], lo}, m_acc[k]);
      end
      bus_rd(8'h00, rd);
      check(48'(rd), {36'h0, m_sticky, m_sat, m_fmt, 1'b0, m_fl});
   endtask

   // Near-limit contents so accumulation overflow is reachable
   task automatic preload();
      logic [15:0] tops [4] = '{16'h7FFF, 16'h8000, 16'h0000, 16'hFFFF};
      logic [31:0] r;
      for (int k = 0; k < 4; k++) begin
         r = $urandom;
         m_acc[k] = {tops[$urandom % 4], r};
         bus_wr(8'h10 + 8'(4 * k), r);
         bus_wr(8'h20 + 8'(4 * k), {16'h0000, m_acc[k][47:32]});
      end
   endtask

   task automatic model(input msd_op_type op);
      logic [15:0] hx, hy;
      logic [31:0] x, y;
      logic [63:0] pr;
      logic [71:0] pf;
      logic [47:0] p, a, r, top, bot;
      logic povf, ins, aovf, uns;
      int k;
      k = op.acc_idx;
      a = m_acc[k];
      r = a;
      uns = (m_fmt == 2'h2);
      if (!(m_sat && m_sticky[k])) begin
         m_sticky[k] = 1'b0;
         povf = 1'b0;
         hx = op.upper_half_sel_x ? op.operand_x[31:16] : op.operand_x[15:0];
         hy = op.upper_half_sel_y ? op.operand_y[31:16] : op.operand_y[15:0];
         if (m_fmt[0]) begin
            x = op.long_size ? op.operand_x : {hx, 16'h0000};
            y = op.long_size ? op.operand_y : {hy, 16'h0000};
            pr = $signed({{32{x[31]}}, x}) * $signed({{32{y[31]}}, y});
            pr = pr << 1;
            pf = (x == 32'h8000_0000 && y == 32'h8000_0000) ? {8'h00, pr} : {{8{pr[63]}}, pr};
            p = pf[71:24];
         end else begin
            x = op.long_size ? op.operand_x : uns ? {16'h0000, hx} : {{16{hx[15]}}, hx};
            y = op.long_size ? op.operand_y : uns ? {16'h0000, hy} : {{16{hy[15]}}, hy};
            pr = {{32{x[31] & !uns}}, x} * {{32{y[31] & !uns}}, y};
            povf = uns ? |pr[63:40] : !(&pr[63:39] || ~|pr[63:39]);
            p = {{8{pr[39] & !uns}}, pr[39:0]};
            ins = (uns || (op.long_size && povf)) ? 1'b0 : pr[39];
            case (op.product_scale_factor)
               2'h1: p = {p[46:0], 1'b0};
               2'h3: p = {p[47:40], ins, p[39:1]};
               default: p = p;
            endcase
         end
         r = op.subtract ? a - p : a + p;
         aovf = op.subtract ? (a[47] != p[47]) : (a[47] == p[47]);
         aovf = uns ? (op.subtract ? (p > a) : (r < a)) : (aovf && (r[47] != a[47]));
         top = uns ? 48'hFFFF_FFFF_FFFF : m_fmt[0] ? 48'h007F_FFFF_FF00 : 48'h0000_7FFF_FFFF;
         bot = uns ? 48'h0000_0000_0000 : m_fmt[0] ? 48'hFF80_0000_0000 : 48'hFFFF_8000_0000;
         if (povf) begin
            m_sticky[k] = 1'b1;
            if (m_sat) r = (uns ? op.subtract : (pr[63] ^ op.subtract)) ? bot : top;
         end else if (aovf) begin
            m_sticky[k] = 1'b1;
            if (m_sat) r = (uns ? op.subtract : !r[47]) ? bot : top;
         end
      end
      m_acc[k] = r;
      m_fl = {r[47], r == 48'h0, m_sticky[k],
         uns ? |r[47:32] : m_fmt[0] ? !(&r[47:39] || ~|r[47:39]) : !(&r[47:31] || ~|r[47:31])};
   endtask

   // Random operations, mostly back to back, with the core stalling now and then
   task automatic burst(input int n, input logic minus_one);
      msd_op_type op;
      logic go, pend;
      pend = 1'b0;
      for (int i = 0; i <= n; i++) begin
         op = 72'({$urandom, $urandom, $urandom});
         if (minus_one && i == 0) op = {op[71], 1'b0, op[69:64], 32'h8000_8000, 32'h8000_8000};
         go = (i < n) && ($urandom % 5 != 0);
         if (go) CORE.issue(op);
         else CORE.idle();
         #1;
         check({o_mac_done, o_flags}, {pend, m_fl});
         pend = go;
         if (go) model(op);
      end
   endtask

   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      i_rst = 1'b1;
      i_bus = '0;
      m_acc = '{default: 48'h0};
      {m_sat, m_fmt, m_sticky, m_fl} = '0;
      void'($urandom(30));
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      chk_all();
      bus_wr(8'h40, 32'hFFFF_FFFF);
      bus_rd(8'h40, rd);
      check(48'(rd), 48'h0);
      chk_all();
      $display("Test reset and unmapped done");
      for (int s = 0; s < 2; s++) begin
         set_status(s[0], 2'h0);
         preload();
         burst(60, 1'b0);
         chk_all();
         burst(20, 1'b0);
         chk_all();
         $display("Test signed integer, saturation %0d done", s);
      end
      // Fractional and unsigned, each with and without saturation
      for (int f = 1; f < 6; f++) begin
         set_status(f > 3, 2'((f > 3) ? f - 2 : f));
         preload();
         burst(30, f[0]);
         chk_all();
         $display("Test format %0d, saturation %0d done", 2'((f > 3) ? f - 2 : f), f > 3);
      end
      // Reset in mid-run must clear everything software left behind
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      m_acc = '{default: 48'h0};
      {m_sat, m_fmt, m_sticky, m_fl} = '0;
      chk_all();
      $display("Test reset after activity done");
      finish_test();
   end

   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
endmodule
